// ---- test/scspi_peer.sv ----
// serial peer standing in for the interface chip on the card side
// assumes the master samples on the falling clock, selects active low
`timescale 1ns/1ps
module scspi_peer (
	input wire logic i_sclk,
	input wire logic i_mosi,
	input wire logic i_sel_first_n,
	input wire logic i_sel_second_n,
	input wire logic [7:0] i_reply,
	output logic o_miso,
	output logic [7:0] o_got,
	output logic [1:0] o_got_sel
);
	logic [7:0] sh;
	initial begin
		o_miso = 1'b0;
		o_got = 8'h00;
		o_got_sel = 2'b00;
		sh = 8'h00;
	end
	// first bit ready as soon as selected
	always @(negedge i_sel_first_n or negedge i_sel_second_n) begin
		sh = i_reply;
		o_miso = sh[7];
	end
	// next bit after each falling edge, once the old one was taken
	always @(negedge i_sclk) begin
		if (!(i_sel_first_n && i_sel_second_n)) begin
			sh = {sh[6:0], 1'b0};
			o_miso = sh[7];
		end
	end
	always @(posedge i_sclk) begin
		o_got <= {o_got[6:0], i_mosi};
		o_got_sel <= {~i_sel_second_n, ~i_sel_first_n};
	end
	// released line shows the inverse of its last value
	always @(posedge i_sel_first_n or posedge i_sel_second_n) begin
		o_miso = ~o_miso;
	end
endmodule

// ---- test/tb_scspi_ctrl.sv ----
// self-checking bench for the smart card serial front end
// assumes scspi_ctrl and the peer model; inputs change on falling clock
`timescale 1ns/1ps
module tb_scspi_ctrl;
	logic i_core_clk, i_rst_n, i_data_wr, i_data_slot, i_div_wr, i_cmd_req;
	logic i_supply_on_command, i_card_reset_low_bit, i_cmd_slot;
	logic i_serial_data_in, i_rx_ready, i_sim_wr, i_sim_choice, i_dma_wr;
	logic i_combined_alarm_in_n, i_status_read;
	logic [7:0] i_data_byte, o_rx_data, reply, got;
	logic [3:0] i_div_value;
	logic [2:0] i_cmd_target, i_dma_rx_map, i_dma_tx_map;
	logic [1:0] i_card_clock_div_reg, i_supply_voltage, i_card_active;
	logic [1:0] i_card_clk, i_card_io, i_card_rx_avail, i_card_tx_space;
	logic [1:0] i_card_irq, o_dma_req, got_sel;
	logic [4:0] i_alarm_mask_reg, o_alarm_status_reg;
	logic [8:0] o_serial_data_reg;
	logic o_serial_clock_out, o_serial_data_out, o_iface_select_first_n;
	logic o_iface_select_second_n, o_rx_valid, o_sim_choice, o_main_clk;
	logic o_main_io, o_sim_clk, o_sim_io, o_alarm_irq;
	int n_mismatch = 0, samples_checked = 0, cyc = 0, hi = 0, hi_last = 0;

	scspi_ctrl dut_u (.*);
	scspi_peer peer_u (
		.i_sclk(o_serial_clock_out),
		.i_mosi(o_serial_data_out),
		.i_sel_first_n(o_iface_select_first_n),
		.i_sel_second_n(o_iface_select_second_n),
		.i_reply(reply),
		.o_miso(i_serial_data_in),
		.o_got(got),
		.o_got_sel(got_sel)
	);

	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [8:0] g, input logic [8:0] e,
		input string m);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task summarize;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// serial clock high width and idle level, plus run ceiling
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (o_serial_clock_out) hi <= hi + 1;
		else if (hi != 0) begin
			hi_last <= hi;
			hi <= 0;
		end
		if (o_serial_clock_out && o_iface_select_first_n &&
			o_iface_select_second_n) cmp(1, 0, "clock not idle");
		if (cyc == 20000) begin
			n_mismatch++;
			summarize;
		end
	end
	task tick(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask
	task wait_valid;
		for (int k = 0; k < 800 && o_serial_data_reg[8] !== 1'b1; k++) tick(1);
	endtask
	task wait_sel(input logic l);
		for (int k = 0; k < 800 && (o_iface_select_first_n &
			o_iface_select_second_n) !== l; k++) tick(1);
	endtask
	task pulse_read;
		i_status_read = 1'b1;
		tick(1);
		i_status_read = 1'b0;
		tick(2);
	endtask
	task wr(input logic [7:0] b, input logic s, input logic [7:0] r);
		tick(1);
		reply = r;
		i_data_byte = b;
		i_data_slot = s;
		i_data_wr = 1'b1;
		tick(1);
		i_data_wr = 1'b0;
	endtask
	task xfer(input logic [7:0] b, input logic s, input logic [7:0] r,
		input logic chk);
		wr(b, s, r);
		tick(1);
		cmp(o_serial_data_reg[8], 0, "busy bit");
		wait_valid;
		if (chk) cmp(o_serial_data_reg, {1'b1, r}, "rx byte");
		cmp(got, b, "tx byte");
		cmp(got_sel, s ? 2'b10 : 2'b01, "select");
	endtask
	task cmd(input logic [2:0] t, input logic r, input logic [1:0] k,
		input logic on, input logic [1:0] v, input logic s);
		tick(1);
		i_cmd_target = t;
		i_card_reset_low_bit = r;
		i_card_clock_div_reg = k;
		i_supply_on_command = on;
		i_supply_voltage = v;
		i_cmd_slot = s;
		tick(1);
		i_cmd_req = 1'b1;
		tick(1);
		i_cmd_req = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////
	task t_reset;
		i_rst_n = 1'b0;
		tick(9);
		cmp({o_iface_select_first_n, o_iface_select_second_n,
			o_serial_clock_out, o_sim_choice, o_dma_req, o_alarm_irq},
			9'h060, "reset pins");
		cmp(o_serial_data_reg, 9'h000, "reset data");
		i_rst_n = 1'b1;
		tick(3);
		cmp(o_dma_req, 2'b00, "dma unmapped");
	endtask
	task automatic t_div;
		int ds[3] = '{15, 0, 3};
		foreach (ds[i]) begin
			tick(1);
			i_div_value = ds[i];
			i_div_wr = 1'b1;
			tick(1);
			i_div_wr = 1'b0;
			xfer(8'hA5 ^ ds[i], ds[i] & 1, 8'h3C + ds[i], ds[i] != 0);
			cmp(hi_last, ds[i] + 1, "clock ratio");
		end
	endtask
	task t_coll;
		i_alarm_mask_reg = 5'h01;
		wr(8'h5A, 1'b0, 8'h66);
		tick(20);
		wr(8'hFF, 1'b1, 8'h00);
		tick(2);
		cmp(o_alarm_status_reg[0], 1, "collision");
		tick(1);
		cmp(o_alarm_irq, 1, "collision irq");
		wait_valid;
		cmp(got, 8'h5A, "kept byte");
		cmp(o_serial_data_reg, 9'h166, "kept rx");
		pulse_read;
		cmp(o_alarm_status_reg[0], 0, "collision clear");
		cmp(o_alarm_irq, 0, "irq clear");
	endtask
	task t_cmd;
		wr(8'h11, 1'b1, 8'h77);
		cmd(3'h4, 1'b1, 2'h2, 1'b1, 2'h3, 1'b0);
		wait_valid;
		reply = 8'hE4;
		cmp(o_serial_data_reg, 9'h177, "data first");
		cmp(got, 8'h11, "data intact");
		wait_sel(0);
		wait_sel(1);
		tick(2);
		cmp(got, 8'h9B, "power on word");
		cmp(got_sel, 2'b01, "cmd select");
		cmp(o_serial_data_reg, 9'h177, "cmd rx dropped");
		cmd(3'h0, 1'b0, 2'h1, 1'b0, 2'h3, 1'b1);
		wait_sel(0);
		wait_sel(1);
		tick(2);
		cmp(got, 8'h04, "power off word");
		cmp(got_sel, 2'b10, "cmd select");
		cmp(o_serial_data_reg, 9'h177, "cmd rx dropped");
	endtask
	task t_fifo;
		i_rx_ready = 1'b0;
		for (int i = 0; i < 8; i++) xfer(8'h80 + i, 1'b0, 8'h20 + i, 1'b1);
		wr(8'hC3, 1'b0, 8'h2F);
		tick(60);
		// full buffer holds off the next byte
		cmp({o_iface_select_first_n, o_iface_select_second_n}, 3,
			"held");
		for (int i = 0; i < 9; i++) begin
			cmp(o_rx_valid, 1, "fifo valid");
			cmp(o_rx_data, i < 8 ? 8'h20 + i : 8'h2F, "fifo data");
			i_rx_ready = 1'b1;
			tick(1);
			i_rx_ready = 1'b0;
			if (i == 0) wait_valid;
			tick(2);
		end
		cmp(o_rx_valid, 0, "fifo empty");
		cmp(got, 8'hC3, "late byte");
		i_rx_ready = 1'b1;
	endtask
	task t_side;
		i_sim_choice = 1'b1;
		i_sim_wr = 1'b1;
		tick(1);
		i_sim_wr = 1'b0;
		tick(1);
		cmp(o_sim_choice, 1, "sim choice");
		i_card_clk = 2'b11;
		i_card_io = 2'b11;
		i_card_active = 2'b01;
		tick(2);
		cmp({o_main_clk, o_main_io, o_sim_clk, o_sim_io}, 4'hC, "main");
		i_card_active = 2'b10;
		tick(2);
		cmp({o_main_clk, o_main_io, o_sim_clk, o_sim_io}, 4'h3, "sim");
		i_card_rx_avail = 2'b01;
		i_card_tx_space = 2'b10;
		// each channel serves one source only
		for (int c = 0; c < 5; c++) begin
			i_dma_rx_map = c;
			i_dma_tx_map = c;
			i_dma_wr = 1'b1;
			tick(1);
			i_dma_wr = 1'b0;
			tick(2);
			cmp(o_dma_req, (c == 1 || c == 4) ? 3 : 0, "dma");
		end
		// channels mapped apart, so a swap of the two maps shows
		i_dma_rx_map = 3'h4;
		i_dma_tx_map = 3'h2;
		i_dma_wr = 1'b1;
		tick(1);
		i_dma_wr = 1'b0;
		tick(2);
		cmp(o_dma_req, 2'b01, "dma split");
		i_dma_rx_map = 3'h7;
		i_dma_tx_map = 3'h1;
		i_dma_wr = 1'b1;
		tick(1);
		i_dma_wr = 1'b0;
		tick(2);
		cmp(o_dma_req, 2'b10, "dma unused code");
		i_alarm_mask_reg = 5'h18;
		i_card_irq = 2'b11;
		i_combined_alarm_in_n = 1'b0;
		tick(6);
		cmp(o_alarm_status_reg, 5'h1E, "alarm status");
		cmp(o_alarm_irq, 1, "alarm irq");
		i_card_irq = 2'b00;
		pulse_read;
		cmp(o_alarm_status_reg, 5'h08, "edge clear");
		i_alarm_mask_reg = 5'h10;
		tick(2);
		cmp(o_alarm_irq, 0, "alarm masked");
		i_combined_alarm_in_n = 1'b1;
		tick(6);
		cmp(o_alarm_status_reg[3], 0, "alarm gone");
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		{i_rst_n, i_data_wr, i_data_slot, i_div_wr, i_cmd_req} = '0;
		{i_supply_on_command, i_card_reset_low_bit, i_cmd_slot} = '0;
		{i_sim_wr, i_sim_choice, i_dma_wr, i_status_read} = '0;
		{i_data_byte, reply, i_div_value, i_cmd_target} = '0;
		{i_dma_rx_map, i_dma_tx_map, i_card_clock_div_reg} = '0;
		{i_supply_voltage, i_card_active, i_card_clk, i_card_io} = '0;
		{i_card_irq, i_alarm_mask_reg} = '0;
		i_card_rx_avail = 2'b11;
		i_card_tx_space = 2'b11;
		i_rx_ready = 1'b1;
		i_combined_alarm_in_n = 1'b1;
		t_reset;
		t_div;
		t_coll;
		t_cmd;
		t_fifo;
		t_side;
		summarize;
	end
endmodule

// ---- verilog/scspi_ctrl.sv ----
// smart card serial front end: spi master, command queue, slot map,
// dma routing, alarm status, plus the receive fifo
// assumes one 100 MHz clock, control bits as plain same-clock ports
//
// What this block does
// - shift 8-bit words out and in, most significant bit first
// - master only, two active-low selects choose the interface chip
// - serial clock rests low, goes high once per bit
// - serial clock is core clock over 2*(divider+1)
// - full duplex: one byte received for each byte sent
// - data write starts transfer; bit 8 low while busy, high when valid
// - byte received during an automatic command is discarded
// - serial input sampled on the falling serial clock edge
// - reset/power request queued, sent once current transfer ends
// - command word opens with 3-bit interface address, 000..011, 100
// - command word carries active-low card reset bit
// - command carries 2-bit clock divider and 2-bit supply, 00 off
// - channel 0 main card, channel 1 sim; inactive lines held low
// - sim choice selects sim driven by channel 1, first after reset
// - each dma channel maps to any card rx/tx or none; none at reset
// - collision flag set when data written during unfinished data transfer
// - alarm status follows the combined active-low alarm input
// - alarm edge flag set on high-to-low alarm transition
// - three sources masked into one alarm irq; card irqs only visible
// - dma requests follow card rx word available and tx space
// - collision flag clears when status is read
`timescale 1ns/1ps
`include "scspi_defs.svh"

module scspi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;
	assign o_out_data = mem[rd_ptr];

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			o_in_ready <= 1'b0;
			o_out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= next_count;
			o_in_ready <= next_count != FULL_CNT;
			o_out_valid <= next_count != '0;
		end
	end
endmodule

module scspi_ctrl
	import scspi_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_data_wr,
	input wire logic [7:0] i_data_byte,
	input wire logic i_data_slot,
	output logic [8:0] o_serial_data_reg,
	input wire logic i_div_wr,
	input wire logic [3:0] i_div_value,
	input wire logic i_cmd_req,
	input wire logic i_supply_on_command,
	input wire logic i_card_reset_low_bit,
	input wire logic [2:0] i_cmd_target,
	input wire logic i_cmd_slot,
	input wire logic [1:0] i_card_clock_div_reg,
	input wire logic [1:0] i_supply_voltage,
	output logic o_serial_clock_out,
	output logic o_serial_data_out,
	input wire logic i_serial_data_in,
	output logic o_iface_select_first_n,
	output logic o_iface_select_second_n,
	output logic o_rx_valid,
	input wire logic i_rx_ready,
	output logic [7:0] o_rx_data,
	input wire logic i_sim_wr,
	input wire logic i_sim_choice,
	output logic o_sim_choice,
	input wire logic [1:0] i_card_active,
	input wire logic [1:0] i_card_clk,
	input wire logic [1:0] i_card_io,
	output logic o_main_clk,
	output logic o_main_io,
	output logic o_sim_clk,
	output logic o_sim_io,
	input wire logic i_dma_wr,
	input wire logic [2:0] i_dma_rx_map,
	input wire logic [2:0] i_dma_tx_map,
	input wire logic [1:0] i_card_rx_avail,
	input wire logic [1:0] i_card_tx_space,
	output logic [1:0] o_dma_req,
	input wire logic i_combined_alarm_in_n,
	input wire logic [1:0] i_card_irq,
	input wire logic [4:0] i_alarm_mask_reg,
	input wire logic i_status_read,
	output logic [4:0] o_alarm_status_reg,
	output logic o_alarm_irq
);
	scspi_state_t state;
	logic [3:0] serial_clock_divider_reg;
	logic [3:0] cur_div;
	logic [3:0] tick;
	logic [2:0] bit_idx;
	logic [7:0] tx_shift;
	logic [7:0] rx_shift;
	logic cur_is_cpu;
	logic cpu_pending;
	logic [7:0] cpu_byte;
	logic cpu_slot;
	logic cmd_pending;
	logic [7:0] cmd_word;
	logic cmd_slot;
	logic cpu_busy;
	logic start_cmd;
	logic start_cpu;
	logic xfer_done;
	logic fifo_ready;
	logic miso_meta;
	logic miso_sync;
	logic alarm_meta;
	logic alarm_sync;
	logic alarm_prev;
	logic alarm_fall;
	logic collide;
	scspi_dma_map_t dma_map [2];
	logic dma_req [2];

	function automatic logic dma_pick(scspi_dma_map_t m,
			logic [1:0] rx, logic [1:0] tx);
		logic r;
		r = 1'b0;
		unique case (m)
			SCSPI_DMA_NONE: r = 1'b0;
			SCSPI_DMA_C0_RX: r = rx[0];
			SCSPI_DMA_C0_TX: r = tx[0];
			SCSPI_DMA_C1_RX: r = rx[1];
			SCSPI_DMA_C1_TX: r = tx[1];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// request handling

	assign cpu_busy = cpu_pending | (state != SCSPI_IDLE & cur_is_cpu);
	assign collide = i_data_wr & cpu_busy;
	assign start_cmd = state == SCSPI_IDLE & cmd_pending;
	assign start_cpu = state == SCSPI_IDLE & !cmd_pending & cpu_pending
		& fifo_ready;
	assign xfer_done = state == SCSPI_HIGH & tick == '0 & bit_idx == 3'h7;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			serial_clock_divider_reg <= `SCSPI_DIV_RST;
		end else if (i_div_wr) begin
			serial_clock_divider_reg <= i_div_value;
		end
	end

	// colliding write is dropped, pending byte kept
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cpu_pending <= 1'b0;
			cpu_byte <= '0;
			cpu_slot <= 1'b0;
		end else if (i_data_wr && !cpu_busy) begin
			cpu_pending <= 1'b1;
			cpu_byte <= i_data_byte;
			cpu_slot <= i_data_slot;
		end else if (start_cpu) begin
			cpu_pending <= 1'b0;
		end
	end

	// a newer request replaces one still waiting
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmd_pending <= 1'b0;
			cmd_word <= '0;
			cmd_slot <= 1'b0;
		end else if (i_cmd_req) begin
			cmd_pending <= 1'b1;
			cmd_slot <= i_cmd_slot;
			cmd_word <= {i_cmd_target, i_card_reset_low_bit,
				i_card_clock_div_reg,
				i_supply_on_command ? i_supply_voltage : `SCSPI_SUPPLY_OFF};
		end else if (start_cmd) begin
			cmd_pending <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial engine

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			miso_meta <= 1'b0;
			miso_sync <= 1'b0;
		end else begin
			miso_meta <= i_serial_data_in;
			miso_sync <= miso_meta;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= SCSPI_IDLE;
			tick <= '0;
			cur_div <= `SCSPI_DIV_RST;
			bit_idx <= '0;
			tx_shift <= '0;
			rx_shift <= '0;
			cur_is_cpu <= 1'b0;
			o_serial_clock_out <= 1'b0;
			o_serial_data_out <= 1'b0;
			o_iface_select_first_n <= 1'b1;
			o_iface_select_second_n <= 1'b1;
		end else begin
			unique case (state)
				SCSPI_IDLE: begin
					if (start_cmd || start_cpu) begin
						state <= SCSPI_LOW;
						tick <= serial_clock_divider_reg;
						cur_div <= serial_clock_divider_reg;
						bit_idx <= '0;
						cur_is_cpu <= start_cpu;
						tx_shift <= start_cmd ? cmd_word : cpu_byte;
						o_serial_data_out <= start_cmd ? cmd_word[7] :
							cpu_byte[7];
						o_iface_select_first_n <= start_cmd ? cmd_slot :
							cpu_slot;
						o_iface_select_second_n <= start_cmd ? !cmd_slot :
							!cpu_slot;
					end
				end
				SCSPI_LOW: begin
					if (tick == '0) begin
						state <= SCSPI_HIGH;
						tick <= cur_div;
						o_serial_clock_out <= 1'b1;
					end else begin
						tick <= tick - 1'b1;
					end
				end
				SCSPI_HIGH: begin
					if (tick == '0) begin
						o_serial_clock_out <= 1'b0;
						rx_shift <= {rx_shift[6:0], miso_sync};
						tx_shift <= {tx_shift[6:0], 1'b0};
						if (bit_idx == 3'h7) begin
							state <= SCSPI_IDLE;
							o_serial_data_out <= 1'b0;
							o_iface_select_first_n <= 1'b1;
							o_iface_select_second_n <= 1'b1;
						end else begin
							state <= SCSPI_LOW;
							tick <= cur_div;
							bit_idx <= bit_idx + 1'b1;
							o_serial_data_out <= tx_shift[6];
						end
					end else begin
						tick <= tick - 1'b1;
					end
				end
			endcase
		end
	end

	// automatic command bytes never reach the data register
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_serial_data_reg <= `SCSPI_DATA_RST;
		end else if (i_data_wr && !cpu_busy) begin
			o_serial_data_reg[`SCSPI_VALID_BIT] <= 1'b0;
		end else if (xfer_done && cur_is_cpu) begin
			o_serial_data_reg <= {1'b1, rx_shift[6:0], miso_sync};
		end
	end

	// stalls new data transfers while full
	scspi_fifo #(
		.WIDTH(`SCSPI_WORD_BITS),
		.DEPTH(`SCSPI_FIFO_DEPTH)
	) rx_fifo (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_in_valid(xfer_done & cur_is_cpu),
		.o_in_ready(fifo_ready),
		.i_in_data({rx_shift[6:0], miso_sync}),
		.o_out_valid(o_rx_valid),
		.i_out_ready(i_rx_ready),
		.o_out_data(o_rx_data)
	);

	////////////////////////////////////////////////////////////////////////
	// card channel map and dma routing

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_sim_choice <= `SCSPI_SIM_RST;
			o_main_clk <= 1'b0;
			o_main_io <= 1'b0;
			o_sim_clk <= 1'b0;
			o_sim_io <= 1'b0;
		end else begin
			if (i_sim_wr) begin
				o_sim_choice <= i_sim_choice;
			end
			o_main_clk <= i_card_active[0] & i_card_clk[0];
			o_main_io <= i_card_active[0] & i_card_io[0];
			o_sim_clk <= i_card_active[1] & i_card_clk[1];
			o_sim_io <= i_card_active[1] & i_card_io[1];
		end
	end

	// one flop per channel, gathered onto the output vector
	assign o_dma_req = {dma_req[1], dma_req[0]};

	for (genvar g = 0; g < 2; g++) begin : g_dma
		always_ff @(posedge i_core_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				dma_map[g] <= SCSPI_DMA_NONE;
				dma_req[g] <= 1'b0;
			end else begin
				if (i_dma_wr) begin
					dma_map[g] <= scspi_dma_map_t'(g == 0 ? i_dma_rx_map :
						i_dma_tx_map);
				end
				dma_req[g] <= dma_pick(dma_map[g], i_card_rx_avail,
					i_card_tx_space);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// alarm status and interrupt

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			alarm_meta <= 1'b1;
			alarm_sync <= 1'b1;
			alarm_prev <= 1'b1;
		end else begin
			alarm_meta <= i_combined_alarm_in_n;
			alarm_sync <= alarm_meta;
			alarm_prev <= alarm_sync;
		end
	end

	assign alarm_fall = alarm_prev & !alarm_sync;

	// collision and edge flags sticky: a new event beats the read clear
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_alarm_status_reg <= '0;
		end else begin
			o_alarm_status_reg[`SCSPI_ST_COLL] <= collide |
				(o_alarm_status_reg[`SCSPI_ST_COLL] & !i_status_read);
			o_alarm_status_reg[`SCSPI_ST_EDGE] <= alarm_fall |
				(o_alarm_status_reg[`SCSPI_ST_EDGE] & !i_status_read);
			o_alarm_status_reg[`SCSPI_ST_ALARM] <= !alarm_sync;
			o_alarm_status_reg[`SCSPI_ST_CARD0] <= i_card_irq[0];
			o_alarm_status_reg[`SCSPI_ST_CARD1] <= i_card_irq[1];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_alarm_irq <= 1'b0;
		end else begin
			o_alarm_irq <= (o_alarm_status_reg[`SCSPI_ST_COLL] &
				i_alarm_mask_reg[`SCSPI_ST_COLL])
				| (o_alarm_status_reg[`SCSPI_ST_ALARM] &
				i_alarm_mask_reg[`SCSPI_ST_ALARM])
				| (o_alarm_status_reg[`SCSPI_ST_EDGE] &
				i_alarm_mask_reg[`SCSPI_ST_EDGE]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	logic [4:0] hi_len;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hi_len <= '0;
		end else begin
			hi_len <= o_serial_clock_out ? hi_len + 1'b1 : '0;
		end
	end

	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	sck_idle_low_a: assert property (
		state == SCSPI_IDLE |-> !o_serial_clock_out)
		else $error("serial clock high while idle");
	select_exclusive_a: assert property (
		!(!o_iface_select_first_n && !o_iface_select_second_n))
		else $error("both interface selects active");
	high_phase_len_a: assert property (
		$fell(o_serial_clock_out) |-> hi_len == {1'b0, cur_div} + 5'h1)
		else $error("serial clock high phase has wrong length");
	collision_flag_a: assert property (
		collide |=> o_alarm_status_reg[`SCSPI_ST_COLL])
		else $error("collision not flagged");
	collision_keeps_a: assert property (
		collide |=> $stable(cpu_byte) && $stable(cpu_slot)
		&& ($past(state) != SCSPI_LOW || $stable(tx_shift)))
		else $error("colliding write disturbed the transfer");
	valid_bit_low_a: assert property (
		i_data_wr && !cpu_busy |=> !o_serial_data_reg[8] throughout
		(cpu_pending [*1]))
		else $error("valid bit not cleared by write");
	auto_discard_a: assert property (
		xfer_done && !cur_is_cpu && !i_data_wr |=>
		$stable(o_serial_data_reg))
		else $error("automatic command changed data register");
	power_off_word_a: assert property (
		i_cmd_req && !i_supply_on_command |=> cmd_word[1:0] == 2'h0)
		else $error("power-off command carries a supply value");
	cmd_sent_a: assert property (
		cmd_pending && state == SCSPI_IDLE |=> state == SCSPI_LOW
		&& !cur_is_cpu)
		else $error("queued command not sent at idle");
	alarm_edge_a: assert property (
		alarm_fall |=> o_alarm_status_reg[`SCSPI_ST_EDGE])
		else $error("alarm edge not flagged");
	irq_masked_a: assert property (
		(i_alarm_mask_reg == 5'h00) [*2] |=> !o_alarm_irq)
		else $error("alarm irq raised while all masked");

	cpu_xfer_c: cover property (xfer_done && cur_is_cpu);
	auto_xfer_c: cover property (xfer_done && !cur_is_cpu);
	collision_c: cover property (collide);
	fifo_full_c: cover property (!fifo_ready && cpu_pending);
endmodule

// ---- verilog/scspi_defs.svh ----
// constants of the smart card serial control block
// assumes inclusion by bare name from the design file
`ifndef SCSPI_DEFS_SVH
`define SCSPI_DEFS_SVH

`define SCSPI_WORD_BITS 8
`define SCSPI_FIFO_DEPTH 8
`define SCSPI_DIV_RST 4'h0
`define SCSPI_SIM_RST 1'b0
`define SCSPI_DATA_RST 9'h000
`define SCSPI_VALID_BIT 8
`define SCSPI_SUPPLY_OFF 2'h0
`define SCSPI_ST_COLL 0
`define SCSPI_ST_CARD0 1
`define SCSPI_ST_CARD1 2
`define SCSPI_ST_ALARM 3
`define SCSPI_ST_EDGE 4
`define SCSPI_IFACE_INTERNAL_IFACE_ONE 3'h0
`define SCSPI_IFACE_EXT 3'h4

`endif

// ---- verilog/scspi_pkg.sv ----
// types shared by the smart card serial control block
// assumes scspi_defs.svh for the numeric constants
package scspi_pkg;
	typedef enum logic [1:0] {
		SCSPI_IDLE,
		SCSPI_LOW,
		SCSPI_HIGH
	} scspi_state_t;

	typedef enum logic [2:0] {
		SCSPI_DMA_NONE,
		SCSPI_DMA_C0_RX,
		SCSPI_DMA_C0_TX,
		SCSPI_DMA_C1_RX,
		SCSPI_DMA_C1_TX
	} scspi_dma_map_t;
endpackage
